// >>> core/lwt_pkg.sv
package lwt_pkg;

   // ****************************************************************
   // Target address layout
   // ****************************************************************
   localparam logic [4:0] ADDR_FIXED     = 5'h0f;   // Upper five bits 01111
   localparam logic [1:0] STRAP_GND      = 2'h0;
   localparam logic [1:0] STRAP_SCL      = 2'h1;
   localparam logic [1:0] STRAP_SDA      = 2'h2;
   localparam logic [1:0] STRAP_VCC      = 2'h3;
   localparam logic       DIR_WRITE      = 1'b0;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam logic [7:0] PTR_RESET      = 8'h00;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int REF_CLK_KHZ   = 25000;
   localparam int SCL_MAX_KHZ   = 400;
   localparam int T_HIGH_MIN_NS = 700;
   localparam int REF_PERIOD_NS = 1000000 / REF_CLK_KHZ;
   // Least high time, rounded up to whole reference cycles
   localparam int HIGH_MIN_CYC  = (T_HIGH_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   // Reference cycles per fastest serial bit, rounded down
   localparam int BIT_MIN_CYC   = REF_CLK_KHZ / SCL_MAX_KHZ;
   localparam int FIFO_DEPTH    = 4;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } lwt_wr_t;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_ADDR  = 8'h02,
      ST_ACK_A = 8'h04,
      ST_REG   = 8'h08,
      ST_ACK_R = 8'h10,
      ST_DATA  = 8'h20,
      ST_ACK_D = 8'h40,
      ST_SKIP  = 8'h80
   } lwt_state_t;

endpackage : lwt_pkg

// >>> core/lwt_fifo.sv
module lwt_fifo
   import lwt_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];

   // ****************************************************************
   // Storage, one flop row per entry
   // ****************************************************************
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            mem_q[i] <= '0;
         end else if (push && wr_ptr_q == AW'(i)) begin
            mem_q[i] <= in_data;
         end
      end
   end

   // Pointers wrap at depth, so depth need not be a power of two
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule : lwt_fifo

// >>> core/lwt_target.sv
module lwt_target
   import lwt_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       strap_i,
   output lwt_wr_t         wr_word,
   output logic            wr_valid,
   input  wire logic       wr_ready
);

   // ****************************************************************
   // Input synchronisers and edge detection
   // ****************************************************************
   logic       scl_s1_q, scl_s2_q, scl_s3_q;
   logic       sda_s1_q, sda_s2_q, sda_s3_q;
   logic       strap_s1_q, strap_s2_q;
   logic       scl_rise, scl_fall, start_det, stop_det;

   // Pins cross into ref_clk through two flops; third flop only for edges
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
         {strap_s1_q, strap_s2_q}       <= 2'h0;
      end else begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
         {strap_s1_q, strap_s2_q}       <= {strap_i, strap_s1_q};
      end
   end

   assign scl_rise  = scl_s2_q && !scl_s3_q;
   assign scl_fall  = !scl_s2_q && scl_s3_q;
   assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
   assign stop_det  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

   // ****************************************************************
   // Strap classifier
   // ****************************************************************
   localparam logic [1:0] WARM_DONE = 2'h2;   // Edges until strap flops hold the pin

   logic       seen_lo_q, seen_hi_q, miss_scl_q;
   logic [1:0] strap_bits;
   logic [1:0] warm_q;

   // Strap flops reset low, so their first values after reset are not the pin
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         warm_q <= 2'h0;
      end else if (warm_q != WARM_DONE) begin
         warm_q <= warm_q + 2'h1;
      end
   end

   // Sticky history; a strap on a bus line follows that line exactly
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         seen_lo_q  <= 1'b0;
         seen_hi_q  <= 1'b0;
         miss_scl_q <= 1'b0;
      end else if (warm_q == WARM_DONE) begin
         seen_lo_q  <= seen_lo_q || !strap_s2_q;
         seen_hi_q  <= seen_hi_q || strap_s2_q;
         miss_scl_q <= miss_scl_q || (strap_s2_q != scl_s2_q);
      end
   end

   // Decided by the address ack, after the start has split clock from data
   always_comb begin
      if (!seen_hi_q) begin
         strap_bits = STRAP_GND;
      end else if (!seen_lo_q) begin
         strap_bits = STRAP_VCC;
      end else if (!miss_scl_q) begin
         strap_bits = STRAP_SCL;
      end else begin
         strap_bits = STRAP_SDA;
      end
   end

   // ****************************************************************
   // Byte engine
   // ****************************************************************
   lwt_state_t state_q;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] ptr_q;
   logic       byte_done;
   logic       addr_match;
   logic       fifo_ready;
   logic       push;

   assign byte_done  = scl_fall && (bit_cnt_q == BITS_PER_BYTE);
   assign addr_match = (shift_q[7:1] == {ADDR_FIXED, strap_bits})
                       && (shift_q[0] == DIR_WRITE);
   // A full buffer refuses the byte with a missing ack
   assign push       = (state_q == ST_DATA) && byte_done && fifo_ready;

   // Bits are taken on the clock's rising edge, i.e. its stable high
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_q   <= '0;
         bit_cnt_q <= '0;
      end else if (start_det) begin
         bit_cnt_q <= '0;
      end else if (scl_rise && (state_q inside {ST_ADDR, ST_REG, ST_DATA})) begin
         shift_q   <= {shift_q[6:0], sda_s2_q};
         bit_cnt_q <= bit_cnt_q + 1'b1;
      end else if (scl_fall && (state_q inside {ST_ACK_A, ST_ACK_R, ST_ACK_D})) begin
         bit_cnt_q <= '0;
      end
   end

   // Sequencer; start wins from any state, so repeated start restarts
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
      end else if (start_det) begin
         state_q <= ST_ADDR;
      end else if (stop_det) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_ADDR: begin
               if (byte_done) begin
                  state_q <= addr_match ? ST_ACK_A : ST_SKIP;
               end
            end
            ST_ACK_A: begin
               if (scl_fall) state_q <= ST_REG;
            end
            ST_REG: begin
               if (byte_done) state_q <= ST_ACK_R;
            end
            ST_ACK_R: begin
               if (scl_fall) state_q <= ST_DATA;
            end
            ST_DATA: begin
               if (byte_done) state_q <= fifo_ready ? ST_ACK_D : ST_SKIP;
            end
            ST_ACK_D: begin
               if (scl_fall) state_q <= ST_DATA;
            end
            ST_IDLE, ST_SKIP: begin
               state_q <= state_q;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Pointer loads from the register byte and steps during each data ack
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_q <= PTR_RESET;
      end else if ((state_q == ST_REG) && byte_done) begin
         ptr_q <= shift_q;
      end else if ((state_q == ST_ACK_D) && scl_fall) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // Ack drive is raised only on a clock fall, so it can never fake a start
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe <= 1'b0;
      end else if (byte_done) begin
         sda_oe <= ((state_q == ST_ADDR) && addr_match)
                   || (state_q == ST_REG)
                   || push;
      end else if (scl_fall) begin
         sda_oe <= 1'b0;
      end
   end

   // Open drain: only ever pulls low
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Write buffer toward the register bank
   // ****************************************************************
   lwt_wr_t fifo_in;
   assign fifo_in = '{addr: ptr_q, data: shift_q};

   lwt_fifo #(
      .WIDTH ($bits(lwt_wr_t)),
      .DEPTH (FIFO_WORDS)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .in_data   (fifo_in),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .out_data  (wr_word),
      .out_valid (wr_valid),
      .out_ready (wr_ready)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_addr_ok;
      (state_q == ST_ADDR) && byte_done && addr_match;
   endsequence

   sequence s_addr_bad;
      (state_q == ST_ADDR) && byte_done && !addr_match;
   endsequence

   AST_ACK_ON_MATCH: assert property (s_addr_ok |=> sda_oe && state_q == ST_ACK_A)
      else $error("address match not acknowledged");
   AST_NO_ACK_MISS: assert property (s_addr_bad |=> !sda_oe && state_q == ST_SKIP)
      else $error("bad address acknowledged");
   AST_READ_REFUSED: assert property (
      (state_q == ST_ADDR) && byte_done && shift_q[0] |=> !sda_oe)
      else $error("read request acknowledged");
   AST_ACK_HOLDS: assert property (
      sda_oe && scl_s2_q && !start_det && !stop_det |=> sda_oe)
      else $error("ack released while clock high");
   AST_START_RESTART: assert property (start_det |=> state_q == ST_ADDR && bit_cnt_q == 4'h0)
      else $error("start did not restart decoding");
   AST_STOP_IDLE: assert property (stop_det && !start_det |=> state_q == ST_IDLE && !sda_oe)
      else $error("stop did not end transfer");
   AST_PTR_STEP: assert property (
      (state_q == ST_ACK_D) && scl_fall && !start_det && !stop_det
      |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance");
   AST_PUSH_WORD: assert property (push |=> wr_valid)
      else $error("acked data not offered");
   AST_IDLE_QUIET: assert property (state_q inside {ST_IDLE, ST_SKIP} && !byte_done |=> !sda_oe)
      else $error("line driven while idle");
   AST_RATE_MARGIN: assert property (
      (state_q == ST_REG) && byte_done |=> sda_oe && !scl_s2_q)
      else $error("ack not raised within the clock low phase");

endmodule : lwt_target

// >>> sim/lwt_host_model.sv
// ****************************************************************
// Bus controller model: drives the serial clock, pulls data low
// ****************************************************************
module lwt_host_model (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus: clock parked high, data released to the pull-up
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   // Start or repeated start; data falls while the clock is high
   task automatic start_c();
      #80 sda_pull = 1'b0;
      if (!scl) begin
         // Long low phase so an acknowledge pull has ended first
         #160 scl = 1'b1;
      end
      #80 sda_pull = 1'b1;
      #160 scl = 1'b0;
   endtask : start_c

   // Stop: data rises while the clock is high, clock then stands still
   task automatic stop_c();
      #80 sda_pull = 1'b1;
      #80 scl = 1'b1;
      #80 sda_pull = 1'b0;
      #160;
   endtask : stop_c

   // Top n bits of b, data changed only in the low phase
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         #80 sda_pull = ~b[i];
         #80 scl = 1'b1;
         #160 scl = 1'b0;
      end
   endtask : send_bits

   // Whole byte, then release data and sample the answer mid-pulse
   task automatic send_byte(input logic [7:0] b, output logic ack);
      send_bits(b, 8);
      #80 sda_pull = 1'b0;
      #80 scl = 1'b1;
      #80 ack = ~sda_line;
      #80 scl = 1'b0;
   endtask : send_byte
endmodule : lwt_host_model

// >>> sim/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import lwt_pkg::*;

   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   logic        ref_clk, reset_n, wr_ready, wr_valid;
   logic        scl, sda_pull, sda_o, sda_oe, sda_line, strap_i;
   logic [1:0]  strap_mode;
   lwt_wr_t     wr_word;
   lwt_wr_t     exp_q[$];
   int          n_fail, tests_run;

   // Open-drain data wire with pull-up; strap follows its tie
   assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
   assign strap_i  = (strap_mode == STRAP_GND) ? 1'b0 :
                     (strap_mode == STRAP_VCC) ? 1'b1 :
                     (strap_mode == STRAP_SCL) ? scl : sda_line;

   lwt_target #(.FIFO_WORDS(FIFO_DEPTH)) u_dut (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .scl_i    (scl),
      .sda_i    (sda_line),
      .sda_o    (sda_o),
      .sda_oe   (sda_oe),
      .strap_i  (strap_i),
      .wr_word  (wr_word),
      .wr_valid (wr_valid),
      .wr_ready (wr_ready)
   );

   lwt_host_model u_host (
      .scl      (scl),
      .sda_pull (sda_pull),
      .sda_line (sda_line)
   );

   // 25 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict();
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Strap is sampled into a history, so each tie gets a fresh reset
   task automatic do_reset();
      reset_n = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : do_reset

   function automatic logic [7:0] dev_addr(input logic [1:0] ad, input logic dir);
      return {ADDR_FIXED, ad, dir};
   endfunction : dev_addr

   task automatic put(input logic [7:0] b, input logic exp_ack);
      logic ack;
      u_host.send_byte(b, ack);
      check({15'h0, ack}, {15'h0, exp_ack});
   endtask : put

   // Sink was stalled during the transfer; now take n words, then none
   task automatic drain(input int n);
      int w;
      for (int k = 0; k < n; k++) begin
         for (w = 0; w < 200 && wr_valid !== 1'b1; w++) begin
            @(posedge ref_clk);
            #1;
         end
         if (w == 200) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            print_verdict();
         end
         check(wr_word, exp_q.pop_front());
         wr_ready = 1'b1;
         @(posedge ref_clk);
         #1 wr_ready = 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      #1 check({15'h0, wr_valid}, 16'h0000);
   endtask : drain

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Every strap tie: wrong strap bits refused, then a burst at 0xfd
   task automatic sc_strap();
      for (int m = 0; m < 4; m++) begin
         strap_mode = m[1:0];
         do_reset();
         u_host.start_c();
         put(dev_addr(strap_mode ^ 2'h1, DIR_WRITE), 1'b0);
         u_host.stop_c();
         u_host.start_c();
         put(dev_addr(strap_mode, DIR_WRITE), 1'b1);
         put(8'hfd, 1'b1);
         for (int j = 0; j < 3; j++) begin
            put(8'ha0 + 8'(j), 1'b1);
            exp_q.push_back({8'hfd + 8'(j), 8'ha0 + 8'(j)});
         end
         u_host.stop_c();
         drain(3);
      end
   endtask : sc_strap

   // Read direction: no answer to anything until the next start
   task automatic sc_read();
      u_host.start_c();
      put(dev_addr(strap_mode, 1'b1), 1'b0);
      put(8'h10, 1'b0);
      put(8'h99, 1'b0);
      u_host.stop_c();
      drain(0);
   endtask : sc_read

   // Stalled sink: four words fit, the fifth data byte is refused
   task automatic sc_full();
      u_host.start_c();
      put(dev_addr(strap_mode, DIR_WRITE), 1'b1);
      put(8'h10, 1'b1);
      for (int j = 0; j < 4; j++) begin
         put(8'hc0 + 8'(j), 1'b1);
         exp_q.push_back({8'h10 + 8'(j), 8'hc0 + 8'(j)});
      end
      put(8'hc4, 1'b0);
      u_host.stop_c();
      drain(4);
   endtask : sc_full

   // Repeated start inside a byte, then a partial byte cut by stop
   task automatic sc_restart();
      u_host.start_c();
      put(dev_addr(strap_mode, DIR_WRITE), 1'b1);
      put(8'h20, 1'b1);
      u_host.send_bits(8'h55, 4);
      u_host.start_c();
      put(dev_addr(strap_mode, DIR_WRITE), 1'b1);
      put(8'h30, 1'b1);
      put(8'h77, 1'b1);
      exp_q.push_back({8'h30, 8'h77});
      u_host.stop_c();
      drain(1);
      u_host.start_c();
      put(dev_addr(strap_mode, DIR_WRITE), 1'b1);
      put(8'h40, 1'b1);
      u_host.send_bits(8'h66, 5);
      u_host.stop_c();
      drain(0);
   endtask : sc_restart

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      reset_n    = 1'b0;
      wr_ready   = 1'b0;
      strap_mode = STRAP_GND;
      n_fail     = 0;
      tests_run  = 0;
      sc_strap();
      sc_read();
      sc_full();
      sc_restart();
      print_verdict();
   end
endmodule : testbench
